//--- src/led_host_pkg.sv
package led_host_pkg;
	// Clock and timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int INIT_TIME_NS = 10000;
	localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LED_SLOT_NS = 40000;
	localparam int LED_SLOT_CYCLES = LED_SLOT_NS / CLK_PERIOD_NS;
	localparam int ADC_DISCHARGE_NS = 640;
	localparam int ADC_DISCHARGE_CYCLES = ADC_DISCHARGE_NS / CLK_PERIOD_NS;

	// Counter widths
	localparam int INIT_CNT_W = 10;
	localparam int SLOT_CNT_W = 12;
	localparam int ADC_BITS = 8;

	// LED colour select codes
	localparam logic [1:0] LED_NONE = 2'h0;
	localparam logic [1:0] LED_RED = 2'h1;
	localparam logic [1:0] LED_GREEN = 2'h2;
	localparam logic [1:0] LED_BLUE = 2'h3;

	// Control port
	localparam logic [6:0] CTRL_PORT_ADDR = 7'h1b;
	localparam logic [7:0] CTRL_RESET_VALUE = 8'h00;
	localparam int CTRL_SEQ_EN_BIT = 0;
	localparam int CTRL_ADC_START_BIT = 1;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [2:0] {
		CP_IDLE,
		CP_ADDR,
		CP_ADDR_ACK,
		CP_WRITE,
		CP_WRITE_ACK,
		CP_READ,
		CP_READ_ACK
	} ctrl_port_state_t;

	typedef enum logic [1:0] {
		ADC_IDLE,
		ADC_CHARGE,
		ADC_DECIDE,
		ADC_DISCHARGE
	} adc_state_t;
endpackage : led_host_pkg

//--- src/led_select_host_status.sv
// What this block does
// - LED select follows sequence: 00 none, 01 red, 10 green, 11 blue.
// - Both LED select outputs held low while reset is asserted.
// - LED select stays low throughout auto-initialization after reset.
// - Host interrupt shows initialization running, then distinctly its completion.
// - Host interrupt output is high-impedance while reset is held.
// - I2C secondary port is the control port; host is primary.
// - SAR conversion: drive charge ramp, sample comparator against thermistor.
`timescale 1ns/100ps
module led_select_host_status (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic comparator_result_in,
	output logic ramp_charge_out,
	output logic led_color_select_bit0,
	output logic led_color_select_bit1,
	output logic host_irq_out,
	output logic host_irq_oe,
	input wire logic control_port_clock_in,
	output logic control_port_clock_out,
	output logic control_port_clock_oe,
	input wire logic control_port_data_in,
	output logic control_port_data_out,
	output logic control_port_data_oe,
	output logic [7:0] ctrl_write_data,
	output logic ctrl_write_valid,
	output logic [7:0] adc_result
);
	logic rst_meta_q, rst_sync_q, rst_n;
	logic [led_host_pkg::INIT_CNT_W-1:0] init_cnt_q, init_cnt_d;
	logic init_done_q, init_done_d;
	logic [led_host_pkg::SLOT_CNT_W-1:0] slot_cnt_q, slot_cnt_d;
	logic [1:0] color_q, color_d;
	logic irq_out_q, irq_out_d, irq_oe_q, irq_oe_d;
	led_host_pkg::ctrl_port_state_t cp_q, cp_d;
	logic [3:0] bits_q, bits_d;
	logic [7:0] shift_q, shift_d;
	logic [7:0] ctrl_q, ctrl_d;
	logic sda_low_q, sda_low_d;
	logic rw_q, rw_d;
	logic wvalid_q, wvalid_d;
	logic scl_q, sda_q;
	logic scl_rise, scl_fall, bus_start, bus_stop;
	logic adc_start, adc_valid;
	logic [7:0] adc_code;
	logic [7:0] adc_hold_q, adc_hold_d;

	// Reset release through two flops; assertion still acts at once
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	assign rst_n = rst_sync_q;

	// Init timer, colour sequence and interrupt level
	always_comb begin
		init_cnt_d = init_cnt_q;
		init_done_d = init_done_q;
		slot_cnt_d = slot_cnt_q;
		color_d = color_q;
		irq_oe_d = 1'b1;
		irq_out_d = 1'b1;
		if (!init_done_q) begin
			init_cnt_d = init_cnt_q + 1'b1;
			if (init_cnt_q == led_host_pkg::INIT_CNT_W'(led_host_pkg::INIT_CYCLES - 1)) begin
				init_done_d = 1'b1;
			end
			color_d = led_host_pkg::LED_NONE;
		end else if (!ctrl_q[led_host_pkg::CTRL_SEQ_EN_BIT]) begin
			color_d = led_host_pkg::LED_NONE;
			slot_cnt_d = '0;
		end else begin
			slot_cnt_d = slot_cnt_q + 1'b1;
			if (color_q == led_host_pkg::LED_NONE) begin
				color_d = led_host_pkg::LED_RED;
				slot_cnt_d = '0;
			end else if (slot_cnt_q ==
					led_host_pkg::SLOT_CNT_W'(led_host_pkg::LED_SLOT_CYCLES - 1)) begin
				slot_cnt_d = '0;
				if (color_q == led_host_pkg::LED_BLUE) begin
					color_d = led_host_pkg::LED_RED;
				end else begin
					color_d = color_q + 2'h1;
				end
			end
		end
		if (init_done_d) begin
			irq_out_d = 1'b0;
		end
	end

	// reset holds LEDs low and interrupt released
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			init_cnt_q <= '0;
			init_done_q <= 1'b0;
			slot_cnt_q <= '0;
			color_q <= led_host_pkg::LED_NONE;
			irq_out_q <= 1'b0;
			irq_oe_q <= 1'b0;
		end else begin
			init_cnt_q <= init_cnt_d;
			init_done_q <= init_done_d;
			slot_cnt_q <= slot_cnt_d;
			color_q <= color_d;
			irq_out_q <= irq_out_d;
			irq_oe_q <= irq_oe_d;
		end
	end

	// Line edges; pins arrive synchronous, so one stage of history suffices
	assign scl_rise = control_port_clock_in & ~scl_q;
	assign scl_fall = ~control_port_clock_in & scl_q;
	assign bus_start = control_port_clock_in & scl_q & sda_q & ~control_port_data_in;
	assign bus_stop = control_port_clock_in & scl_q & ~sda_q & control_port_data_in;

	// Control port secondary engine
	always_comb begin
		cp_d = cp_q;
		bits_d = bits_q;
		shift_d = shift_q;
		ctrl_d = ctrl_q;
		sda_low_d = sda_low_q;
		rw_d = rw_q;
		wvalid_d = 1'b0;
		adc_hold_d = adc_valid ? adc_code : adc_hold_q;
		if (bus_start) begin
			cp_d = led_host_pkg::CP_ADDR;
			bits_d = 4'h0;
			sda_low_d = 1'b0;
		end else if (bus_stop) begin
			cp_d = led_host_pkg::CP_IDLE;
			sda_low_d = 1'b0;
		end else begin
			case (cp_q)
				led_host_pkg::CP_ADDR, led_host_pkg::CP_WRITE: begin
					if (scl_rise) begin
						shift_d = {shift_q[6:0], control_port_data_in};
						bits_d = bits_q + 4'h1;
					end else if (scl_fall && bits_q == led_host_pkg::BITS_PER_BYTE) begin
						if (cp_q == led_host_pkg::CP_WRITE) begin
							ctrl_d = shift_q;
							wvalid_d = 1'b1;
							sda_low_d = 1'b1;
							cp_d = led_host_pkg::CP_WRITE_ACK;
						end else if (shift_q[7:1] == led_host_pkg::CTRL_PORT_ADDR
								&& init_done_q) begin
							rw_d = shift_q[0];
							sda_low_d = 1'b1;
							cp_d = led_host_pkg::CP_ADDR_ACK;
						end else begin
							cp_d = led_host_pkg::CP_IDLE;
						end
					end
				end
				led_host_pkg::CP_ADDR_ACK, led_host_pkg::CP_WRITE_ACK: begin
					if (scl_fall) begin
						bits_d = 4'h0;
						if (cp_q == led_host_pkg::CP_ADDR_ACK && rw_q) begin
							shift_d = adc_hold_q;
							sda_low_d = ~adc_hold_q[7];
							cp_d = led_host_pkg::CP_READ;
						end else begin
							sda_low_d = 1'b0;
							cp_d = led_host_pkg::CP_WRITE;
						end
					end
				end
				led_host_pkg::CP_READ: begin
					if (scl_rise) begin
						bits_d = bits_q + 4'h1;
					end else if (scl_fall) begin
						if (bits_q == led_host_pkg::BITS_PER_BYTE) begin
							sda_low_d = 1'b0;
							cp_d = led_host_pkg::CP_READ_ACK;
						end else begin
							shift_d = {shift_q[6:0], 1'b0};
							sda_low_d = ~shift_q[6];
						end
					end
				end
				led_host_pkg::CP_READ_ACK: begin
					// Primary's not-acknowledge ends the read
					if (scl_rise && control_port_data_in) begin
						cp_d = led_host_pkg::CP_IDLE;
					end else if (scl_fall) begin
						bits_d = 4'h0;
						shift_d = adc_hold_q;
						sda_low_d = ~adc_hold_q[7];
						cp_d = led_host_pkg::CP_READ;
					end
				end
				default: begin
					sda_low_d = 1'b0;
				end
			endcase
		end
	end

	// Control port registers; lines idle high in reset
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cp_q <= led_host_pkg::CP_IDLE;
			bits_q <= 4'h0;
			shift_q <= 8'h00;
			ctrl_q <= led_host_pkg::CTRL_RESET_VALUE;
			sda_low_q <= 1'b0;
			rw_q <= 1'b0;
			wvalid_q <= 1'b0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			adc_hold_q <= 8'h00;
		end else begin
			cp_q <= cp_d;
			bits_q <= bits_d;
			shift_q <= shift_d;
			ctrl_q <= ctrl_d;
			sda_low_q <= sda_low_d;
			rw_q <= rw_d;
			wvalid_q <= wvalid_d;
			scl_q <= control_port_clock_in;
			sda_q <= control_port_data_in;
			adc_hold_q <= adc_hold_d;
		end
	end

	// Conversion starts on a control write with the start bit set
	assign adc_start = wvalid_q & ctrl_q[led_host_pkg::CTRL_ADC_START_BIT];

	sar_thermistor_adc sar_thermistor_adc_i (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.start(adc_start),
		.comparator_result_in(comparator_result_in),
		.ramp_charge_out(ramp_charge_out),
		.busy(),
		.result(adc_code),
		.result_valid(adc_valid)
	);

	// Pin drivers; clock is never stretched
	assign led_color_select_bit0 = color_q[0];
	assign led_color_select_bit1 = color_q[1];
	assign host_irq_out = irq_out_q;
	assign host_irq_oe = irq_oe_q;
	assign control_port_clock_out = 1'b0;
	assign control_port_clock_oe = 1'b0;
	assign control_port_data_out = 1'b0;
	assign control_port_data_oe = sda_low_q;
	assign ctrl_write_data = ctrl_q;
	assign ctrl_write_valid = wvalid_q;
	assign adc_result = adc_hold_q;
endmodule : led_select_host_status

//--- src/sar_thermistor_adc.sv
`timescale 1ns/100ps
module sar_thermistor_adc (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic comparator_result_in,
	output logic ramp_charge_out,
	output logic busy,
	output logic [7:0] result,
	output logic result_valid
);
	led_host_pkg::adc_state_t st_q, st_d;
	logic [7:0] code_q, code_d;
	logic [7:0] cnt_q, cnt_d;
	logic [2:0] bit_q, bit_d;
	logic [7:0] trial;
	logic ramp_q, ramp_d;
	logic valid_q, valid_d;

	// Trial code sets the bit under test on top of bits already kept
	assign trial = code_q | (8'h01 << bit_q);

	// Sequencer: charge for trial plus one cycles, compare, discharge, next bit
	always_comb begin
		st_d = st_q;
		code_d = code_q;
		cnt_d = cnt_q;
		bit_d = bit_q;
		valid_d = 1'b0;
		case (st_q)
			led_host_pkg::ADC_IDLE: begin
				if (start) begin
					code_d = 8'h00;
					bit_d = 3'(led_host_pkg::ADC_BITS - 1);
					cnt_d = 8'h00;
					st_d = led_host_pkg::ADC_CHARGE;
				end
			end
			led_host_pkg::ADC_CHARGE: begin
				cnt_d = cnt_q + 8'h01;
				if (cnt_q == trial) begin
					st_d = led_host_pkg::ADC_DECIDE;
				end
			end
			led_host_pkg::ADC_DECIDE: begin
				if (!comparator_result_in) begin
					code_d = trial;
				end
				cnt_d = 8'h00;
				st_d = led_host_pkg::ADC_DISCHARGE;
			end
			default: begin
				cnt_d = cnt_q + 8'h01;
				if (cnt_q == 8'(led_host_pkg::ADC_DISCHARGE_CYCLES - 1)) begin
					cnt_d = 8'h00;
					if (bit_q == 3'h0) begin
						valid_d = 1'b1;
						st_d = led_host_pkg::ADC_IDLE;
					end else begin
						bit_d = bit_q - 3'h1;
						st_d = led_host_pkg::ADC_CHARGE;
					end
				end
			end
		endcase
		ramp_d = (st_d == led_host_pkg::ADC_CHARGE);
	end

	// Registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= led_host_pkg::ADC_IDLE;
			code_q <= 8'h00;
			cnt_q <= 8'h00;
			bit_q <= 3'h0;
			ramp_q <= 1'b0;
			valid_q <= 1'b0;
		end else begin
			st_q <= st_d;
			code_q <= code_d;
			cnt_q <= cnt_d;
			bit_q <= bit_d;
			ramp_q <= ramp_d;
			valid_q <= valid_d;
		end
	end

	assign ramp_charge_out = ramp_q;
	assign busy = (st_q != led_host_pkg::ADC_IDLE);
	assign result = code_q;
	assign result_valid = valid_q;
endmodule : sar_thermistor_adc

//--- verification/host_i2c_model.sv
`timescale 1ns/100ps
module host_i2c_model (
	input wire logic sys_clk,
	input wire logic sda_line,
	output logic scl_oe,
	output logic sda_oe
);
	// Lines released at start
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end
	// Five clocks per level, well above the two the port needs
	task automatic hold();
		repeat (5) @(posedge sys_clk);
		#1;
	endtask : hold
	task automatic start();
		sda_oe = 1'b1;
		hold();
		scl_oe = 1'b1;
		hold();
	endtask : start
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_oe = !b[i];
			hold();
			scl_oe = 1'b0;
			hold();
			scl_oe = 1'b1;
			hold();
		end
		sda_oe = 1'b0;
		hold();
		scl_oe = 1'b0;
		hold();
		ack = !sda_line;
		scl_oe = 1'b1;
		hold();
	endtask : put_byte
	// device sends msb first; more high acknowledges for another byte
	task automatic get_byte(output logic [7:0] b, input logic more);
		sda_oe = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			hold();
			scl_oe = 1'b0;
			hold();
			b[i] = sda_line;
			scl_oe = 1'b1;
		end
		hold();
		sda_oe = more;
		hold();
		scl_oe = 1'b0;
		hold();
		scl_oe = 1'b1;
		hold();
	endtask : get_byte
	task automatic stop();
		sda_oe = 1'b1;
		hold();
		scl_oe = 1'b0;
		hold();
		sda_oe = 1'b0;
		hold();
	endtask : stop
endmodule : host_i2c_model

//--- verification/led_select_host_status_asserts.sv
`timescale 1ns/100ps
module led_select_host_status_asserts (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic led_color_select_bit0,
	input wire logic led_color_select_bit1,
	input wire logic host_irq_out,
	input wire logic host_irq_oe,
	input wire logic control_port_data_oe,
	input wire logic ctrl_write_valid
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	logic [1:0] led;
	// Colour code as one value
	assign led = {led_color_select_bit1, led_color_select_bit0};
	// Release edge of reset
	sequence s_release;
		$rose(resetn);
	endsequence
	// Init flag drops once
	sequence s_init_done;
		host_irq_out ##1 !host_irq_out;
	endsequence
	a_reset_led_off: assert property (s_release |-> led == 2'h0 && !host_irq_oe)
		else $error("outputs active at reset release");
	a_init_led_off: assert property (host_irq_out |-> led == 2'h0)
		else $error("led on during init");
	a_init_first: assert property ($rose(host_irq_oe) |-> host_irq_out)
		else $error("irq not showing init");
	a_irq_oe_held: assert property (host_irq_oe |=> host_irq_oe)
		else $error("irq released out of reset");
	a_done_stays: assert property (s_init_done |=> !host_irq_out && host_irq_oe)
		else $error("init done not held");
	a_ack_after_init: assert property (control_port_data_oe |-> !host_irq_out)
		else $error("ack before init done");
	a_led_order: assert property ($past(led) != 2'h0 && led != 2'h0 && led != $past(led)
		|-> led == 2'($past(led) % 2'h3 + 2'h1))
		else $error("colour order wrong");
	// Completion level must never fall back to the running level
	a_done_latched: assert property (host_irq_oe && !host_irq_out |=> host_irq_oe && !host_irq_out)
		else $error("init done level lost");
	a_valid_pulse: assert property (ctrl_write_valid |=> !ctrl_write_valid)
		else $error("write valid too long");
endmodule : led_select_host_status_asserts

bind led_select_host_status led_select_host_status_asserts led_select_host_status_asserts_i (
	.sys_clk, .resetn, .led_color_select_bit0, .led_color_select_bit1, .host_irq_out,
	.host_irq_oe, .control_port_data_oe, .ctrl_write_valid);

//--- verification/led_select_host_status_test.sv
`timescale 1ns/100ps
module led_select_host_status_test;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic ramp_was_q = 1'b0;
	logic [7:0] ramp_cnt_q = 8'h00;
	logic ramp_charge_out, led_color_select_bit0, led_color_select_bit1, ack;
	logic host_irq_out, host_irq_oe, control_port_clock_out, control_port_clock_oe;
	logic control_port_data_out, control_port_data_oe, ctrl_write_valid, scl_oe, sda_oe;
	logic control_port_clock_in, control_port_data_in, comparator_result_in;
	logic [7:0] ctrl_write_data, adc_result;
	logic [1:0] led;
	int n_mismatch = 0;
	int compares = 0;
	int cycles = 0;
	int n_valid = 0;
	localparam logic [7:0] THERM = 8'h65;
	always #5 sys_clk = ~sys_clk;
	// Open-drain lines with pull-ups
	assign control_port_clock_in = !(scl_oe || control_port_clock_oe);
	assign control_port_data_in = !(sda_oe || control_port_data_oe);
	assign led = {led_color_select_bit1, led_color_select_bit0};
	// comparator trips once ramp time passes the thermistor
	assign comparator_result_in = ramp_cnt_q > THERM;
	always @(posedge sys_clk) begin
		ramp_was_q <= ramp_charge_out;
		if (ramp_charge_out)
			ramp_cnt_q <= ramp_was_q ? ramp_cnt_q + 8'h01 : 8'h01;
	end
	led_select_host_status led_select_host_status_i (.sys_clk, .resetn, .comparator_result_in,
		.ramp_charge_out, .led_color_select_bit0, .led_color_select_bit1, .host_irq_out,
		.host_irq_oe, .control_port_clock_in, .control_port_clock_out, .control_port_clock_oe,
		.control_port_data_in, .control_port_data_out, .control_port_data_oe,
		.ctrl_write_data, .ctrl_write_valid, .adc_result);
	host_i2c_model host_i2c_model_i (.sys_clk, .sda_line(control_port_data_in), .scl_oe,
		.sda_oe);
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_sim();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask : tick
	// One control write: address 0x1b with write bit, then a byte
	task automatic write_ctrl(input logic [7:0] b, input logic exp_ack);
		host_i2c_model_i.start();
		host_i2c_model_i.put_byte(8'h36, ack);
		check(ack, exp_ack);
		if (ack)
			host_i2c_model_i.put_byte(b, ack);
		host_i2c_model_i.stop();
	endtask : write_ctrl
	task automatic t_reset();
		repeat (8) tick();
		check(led, 2'h0);
		check(host_irq_oe, 1'b0);
		resetn = 1'b1;
		repeat (4) tick();
		check(host_irq_out, 1'b1);
		check(led, 2'h0);
		// Host jumps the gun here on purpose
		write_ctrl(8'h01, 1'b0);
		check(ctrl_write_data, 8'h00);
		check(16'(n_valid), 16'h0000);
	endtask : t_reset
	task automatic t_init();
		int n = 0;
		// hold off until init reported done
		while (host_irq_out === 1'b1 && n < 1100) begin
			tick();
			n++;
		end
		check(host_irq_out, 1'b0);
		check(host_irq_oe, 1'b1);
	endtask : t_init
	task automatic t_leds();
		logic [1:0] cur;
		int n;
		cur = 2'h1;
		write_ctrl(8'h01, 1'b1);
		check(ctrl_write_data, 8'h01);
		check(16'(n_valid), 16'h0001);
		check(led, cur);
		for (int c = 0; c < 3; c++) begin
			n = 0;
			while (led === cur && n < 4100) begin
				tick();
				n++;
			end
			cur = 2'(cur % 2'h3 + 2'h1);
			check(led, cur);
			if (c > 0)
				check(16'(n), 16'(led_host_pkg::LED_SLOT_CYCLES));
		end
	endtask : t_leds
	task automatic t_adc();
		int n = 0;
		write_ctrl(8'h02, 1'b1);
		check(led, 2'h0);
		while (adc_result === 8'h00 && n < 4000) begin
			tick();
			n++;
		end
		check(adc_result, THERM - 8'h01);
	endtask : t_adc
	// Reset while the colours run, then a second init
	task automatic t_rerun();
		resetn = 1'b0;
		tick();
		check(led, 2'h0);
		check(host_irq_oe, 1'b0);
		repeat (7) tick();
		check(led, 2'h0);
		resetn = 1'b1;
		repeat (4) tick();
		check(host_irq_out, 1'b1);
		check(led, 2'h0);
		t_init();
	endtask : t_rerun
	// Two byte read of the held conversion, ack then not-ack
	task automatic t_read();
		logic [7:0] b;
		host_i2c_model_i.start();
		host_i2c_model_i.put_byte(8'h37, ack);
		check(ack, 1'b1);
		host_i2c_model_i.get_byte(b, 1'b1);
		check(b, THERM - 8'h01);
		host_i2c_model_i.get_byte(b, 1'b0);
		check(b, THERM - 8'h01);
		host_i2c_model_i.stop();
		check(16'(n_valid), 16'h0002);
		check({control_port_clock_oe, control_port_clock_out, control_port_data_out}, 3'h0);
	endtask : t_read
	// Main sequence
	initial begin
		t_reset();
		t_init();
		t_leds();
		t_rerun();
		t_adc();
		t_read();
		end_sim();
	end
	// Hang guard, run needs about 16300 cycles; also counts write pulses
	always @(posedge sys_clk) begin
		if (ctrl_write_valid === 1'b1)
			n_valid++;
		cycles++;
		if (cycles == 40000) begin
			n_mismatch++;
			end_sim();
		end
	end
endmodule : led_select_host_status_test
